// ==== inc/aes_regs.svh ====
/*
  register offsets, field positions and reset values of the adapter error summary block.
  assumes inclusion by bare name from the package; design modules use its macros without including it.
*/
`ifndef AES_REGS_SVH
`define AES_REGS_SVH

`define AES_OFF_ERROR_SUMMARY   12'h000
`define AES_OFF_CONTROL_STATUS  12'h004
`define AES_OFF_FAILING_ADDRESS 12'h008

`define AES_BIT_PARITY          0
`define AES_BIT_ACK_NO_PEND     1
`define AES_BIT_INTLK_FAIL      2
`define AES_BIT_ILLEGAL_CMD     3
`define AES_BIT_MASTER_FAIL     4
`define AES_BIT_SLAVE_FAIL      5
`define AES_BIT_CA_FAIL         6
`define AES_BIT_MULT_ERR        7

`define AES_CSR_PARITY_MASK     0
`define AES_CSR_INTLK_MASK      1

`define AES_RST_MASTER_FAIL     1'b1
`define AES_RST_SUMMARY         8'h10
`define AES_RST_CONTROL         2'h0
`define AES_RST_FAIL_ADDR       32'h0000_0000

`define AES_RESP_OKAY           2'h0
`define AES_RESP_SLVERR         2'h2

`endif

// ==== inc/aes_pkg.sv ====
/*
  types shared by the adapter error summary design.
  assumes aes_regs.svh on the include path.
*/
package aes_pkg;
  `include "aes_regs.svh"

  // one fetch reported by the link sequencers
  typedef struct packed {
    logic        valid;
    logic        parity_err;
    logic        by_slave;
    logic        is_ca;
    logic        dma_read;
  } aes_fetch_s;

  // transaction decode events from the command decoder
  typedef struct packed {
    logic        io_txn;
    logic        illegal_cmd;
    logic        intlk_read;
    logic        illegal_confirm_slave_data;
    logic        ack_txn;
    logic        passive_release;
    logic [3:0]  interrupt_priority_level;
    logic        dma_ca;
    logic [31:0] dma_address;
  } aes_event_s;

  typedef enum logic [1:0] {
    AES_WR_IDLE,
    AES_WR_RESP
  } aes_wr_e;
endpackage

// ==== verilog/aes_lock_capture.sv ====
/*
  failing address capture register with freeze control.
  assumes freeze inputs come from the error summary flags.
*/
`timescale 1ns/1ps
`default_nettype none
module aes_lock_capture
  import aes_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        reset_n,
  input  wire logic        load,
  input  wire logic [31:0] load_value,
  input  wire logic        frozen,
  output logic      [31:0] value
);
  typedef struct packed {
    logic [31:0] addr_r;
  } aes_cap_s;

  aes_cap_s st_r;
  aes_cap_s st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (load && !frozen) begin
      st_nxt.addr_r = load_value;
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      st_r.addr_r <= `AES_RST_FAIL_ADDR;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign value = st_r.addr_r;
endmodule
`default_nettype wire

// ==== verilog/aes_pending_check.sv ====
/*
  decides whether an interrupt acknowledge finds a pending request at its level.
  assumes pending vector bit n is priority level n.
*/
`timescale 1ns/1ps
`default_nettype none
module aes_pending_check
  import aes_pkg::*;
(
  input  wire logic [15:0] pending,
  input  wire logic [3:0]  level,
  output logic             none_pending
);
  logic [15:0] hit;

  genvar g;
  generate
    for (g = 0; g < 16; g++) begin : g_lvl
      assign hit[g] = pending[g] && (level == 4'(g));
    end
  endgenerate

  assign none_pending = ~|hit;
endmodule
`default_nettype wire

// ==== verilog/aes_error_summary.sv ====
/*
  adapter error summary register bank on an axi4-lite slave.
  assumes link events arrive as one-cycle pulses synchronous to clock.
*/
// Decided for this implementation: the AXI4-Lite interface to the registers and the address map.
// Contract
// (R1) slave-fail bit with parity bit flags parity error on slave read-data fetch
// (R2) master-fail bit resets to one and sets on every i/o transaction; the code sets it only while the parity bit is clear
// (R3) master-fail with parity bit marks parity error on master fetch
// (R4) illegal command sets bit, terminates transaction, signals failure to peer
// (R5) interlocked read with illegal confirm sets bit and freezes failing address
// (R6) writing one clears interlock-read-failed bit and its address freeze
// (R7) interlock-read-failed with its mask raises error interrupt
// (R8) acknowledge with nothing pending sets error bit and tells peer it failed
// (R9) passive release never sets the acknowledge error bit
// (R10) waiting processors cancel duplicate acknowledges of same node and level
// (R11) parity error sets bit, freezes bits six to four, maybe failing address
// (R12) clearing parity bit releases both freezes
// (R13) parity bit with its control mask raises error interrupt
// (R14) failing address captures every dma command/address unless frozen
// (R15) zero writes leave error bits; read-only bits ignore writes
`timescale 1ns/1ps
`default_nettype none
module aes_error_summary
  import aes_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        reset_n,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire aes_fetch_s  fetch,
  input  wire aes_event_s  evt,
  input  wire logic [15:0] pending_levels,
  output logic             peer_fail,
  output logic             error_irq
);
  typedef struct packed {
    logic [7:0]  summary_r;
    logic [1:0]  control_r;
    logic        aw_got_r;
    logic        w_got_r;
    logic [11:0] awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0]  wstrb_r;
    aes_wr_e     wr_state_r;
    logic        awready_r;
    logic        wready_r;
    logic        bvalid_r;
    logic [1:0]  bresp_r;
    logic        arready_r;
    logic        rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0]  rresp_r;
    logic        peer_fail_r;
    logic        irq_r;
    logic        addr_lock_r;
  } aes_state_s;

  aes_state_s  st_r;
  aes_state_s  st_nxt;
  logic [31:0] fail_addr;
  logic        none_pending;
  logic        addr_frozen;

  function automatic logic is_mapped(input logic [11:0] a);
    is_mapped = (a == `AES_OFF_ERROR_SUMMARY) || (a == `AES_OFF_CONTROL_STATUS) ||
                (a == `AES_OFF_FAILING_ADDRESS);
  endfunction

  aes_pending_check u_pend (
    .pending      (pending_levels),
    .level        (evt.interrupt_priority_level),
    .none_pending (none_pending)
  );

  // interlock failure, or a parity error on dma read return data, holds the address
  assign addr_frozen = st_r.summary_r[`AES_BIT_INTLK_FAIL] || st_r.addr_lock_r; // [R5] [R6] [R11] [R12]

  aes_lock_capture u_cap (
    .clock      (clock),
    .reset_n    (reset_n),
    .load       (evt.dma_ca),                                          // [R14]
    .load_value (evt.dma_address),
    .frozen     (addr_frozen),
    .value      (fail_addr)
  );

  always_comb begin
    logic        do_write;
    logic [7:0]  w1c;
    logic [7:0]  sets;
    logic        par_locked;
    logic [11:0] wa;
    do_write   = 1'b0;
    w1c        = 8'h00;
    sets       = 8'h00;
    par_locked = st_r.summary_r[`AES_BIT_PARITY];
    wa         = st_r.awaddr_r;
    st_nxt     = st_r;
    st_nxt.peer_fail_r = 1'b0;

    // write channels accepted in either order, one write at a time
    if (st_r.awready_r && s_axi_awvalid) begin
      st_nxt.aw_got_r  = 1'b1;
      st_nxt.awaddr_r  = s_axi_awaddr;
      st_nxt.awready_r = 1'b0;
    end
    if (st_r.wready_r && s_axi_wvalid) begin
      st_nxt.w_got_r  = 1'b1;
      st_nxt.wdata_r  = s_axi_wdata;
      st_nxt.wstrb_r  = s_axi_wstrb;
      st_nxt.wready_r = 1'b0;
    end
    case (st_r.wr_state_r)
      AES_WR_IDLE: begin
        if (st_r.aw_got_r && st_r.w_got_r) begin
          do_write          = 1'b1;
          st_nxt.bvalid_r   = 1'b1;
          st_nxt.bresp_r    = is_mapped(wa) ? `AES_RESP_OKAY : `AES_RESP_SLVERR;
          st_nxt.wr_state_r = AES_WR_RESP;
        end
      end
      AES_WR_RESP: begin
        if (s_axi_bready) begin
          st_nxt.bvalid_r   = 1'b0;
          st_nxt.aw_got_r   = 1'b0;
          st_nxt.w_got_r    = 1'b0;
          st_nxt.awready_r  = 1'b1;
          st_nxt.wready_r   = 1'b1;
          st_nxt.wr_state_r = AES_WR_IDLE;
        end
      end
      default: st_nxt.wr_state_r = AES_WR_IDLE;
    endcase

    if (do_write && st_r.wstrb_r[0]) begin
      if (wa == `AES_OFF_ERROR_SUMMARY) begin
        // only write-one-to-clear bits respond; sequencer status bits are read only
        w1c = st_r.wdata_r[7:0] & 8'h8f;                             // [R15]
      end
      if (wa == `AES_OFF_CONTROL_STATUS) begin
        st_nxt.control_r = st_r.wdata_r[1:0];
      end
    end

    // hardware events
    if (evt.io_txn && !par_locked) begin
      sets[`AES_BIT_MASTER_FAIL] = 1'b1;                             // [R2]
    end
    if (evt.illegal_cmd) begin
      sets[`AES_BIT_ILLEGAL_CMD] = 1'b1;                             // [R4]
      st_nxt.peer_fail_r         = 1'b1;                             // [R4]
    end
    if (evt.intlk_read && evt.illegal_confirm_slave_data) begin
      sets[`AES_BIT_INTLK_FAIL] = 1'b1;                              // [R5]
    end
    if (evt.ack_txn && none_pending && !evt.passive_release) begin  // [R9]
      sets[`AES_BIT_ACK_NO_PEND] = 1'b1;                             // [R8]
      st_nxt.peer_fail_r         = 1'b1;                             // [R8]
    end
    if (fetch.valid && fetch.parity_err) begin
      sets[`AES_BIT_PARITY] = 1'b1;                                  // [R11]
      if (par_locked && st_r.summary_r[`AES_BIT_ILLEGAL_CMD]) begin
        sets[`AES_BIT_MULT_ERR] = 1'b1;
      end
    end

    // set beats clear in the same cycle
    st_nxt.summary_r = (st_r.summary_r & ~w1c) | sets;               // [R6] [R15]
    // locked field 6:4 follows the fetch only while the parity bit is clear
    if (!par_locked) begin                                           // [R11] [R12]
      if (fetch.valid && fetch.parity_err) begin
        st_nxt.summary_r[`AES_BIT_SLAVE_FAIL]  = fetch.by_slave;     // [R1]
        st_nxt.summary_r[`AES_BIT_MASTER_FAIL] = !fetch.by_slave;    // [R3]
        st_nxt.summary_r[`AES_BIT_CA_FAIL]     = fetch.is_ca;
      end
    end else begin
      st_nxt.summary_r[6:4] = st_r.summary_r[6:4];
    end
    // other fetch failures leave the address free, so dma capture keeps running
    st_nxt.addr_lock_r = (st_r.addr_lock_r && st_nxt.summary_r[`AES_BIT_PARITY]) ||
                         (fetch.valid && fetch.parity_err && fetch.dma_read);   // [R11] [R12]

    st_nxt.irq_r = (st_nxt.summary_r[`AES_BIT_PARITY] && st_nxt.control_r[`AES_CSR_PARITY_MASK]) || // [R13]
                   (st_nxt.summary_r[`AES_BIT_INTLK_FAIL] && st_nxt.control_r[`AES_CSR_INTLK_MASK]); // [R7]

    // read channel
    if (st_r.arready_r && s_axi_arvalid) begin
      st_nxt.arready_r = 1'b0;
      st_nxt.rvalid_r  = 1'b1;
      st_nxt.rresp_r   = is_mapped(s_axi_araddr) ? `AES_RESP_OKAY : `AES_RESP_SLVERR;
      case (s_axi_araddr)
        `AES_OFF_ERROR_SUMMARY:   st_nxt.rdata_r = {24'h000000, st_r.summary_r};
        `AES_OFF_CONTROL_STATUS:  st_nxt.rdata_r = {30'h0, st_r.control_r};
        `AES_OFF_FAILING_ADDRESS: st_nxt.rdata_r = fail_addr;
        default:                  st_nxt.rdata_r = 32'h0000_0000;
      endcase
    end else if (st_r.rvalid_r && s_axi_rready) begin
      st_nxt.rvalid_r  = 1'b0;
      st_nxt.arready_r = 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      st_r.summary_r   <= `AES_RST_SUMMARY;
      st_r.control_r   <= `AES_RST_CONTROL;
      st_r.aw_got_r    <= 1'b0;
      st_r.w_got_r     <= 1'b0;
      st_r.awaddr_r    <= 12'h000;
      st_r.wdata_r     <= 32'h0000_0000;
      st_r.wstrb_r     <= 4'h0;
      st_r.wr_state_r  <= AES_WR_IDLE;
      st_r.awready_r   <= 1'b1;
      st_r.wready_r    <= 1'b1;
      st_r.bvalid_r    <= 1'b0;
      st_r.bresp_r     <= `AES_RESP_OKAY;
      st_r.arready_r   <= 1'b1;
      st_r.rvalid_r    <= 1'b0;
      st_r.rdata_r     <= 32'h0000_0000;
      st_r.rresp_r     <= `AES_RESP_OKAY;
      st_r.peer_fail_r <= 1'b0;
      st_r.irq_r       <= 1'b0;
      st_r.addr_lock_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign s_axi_awready = st_r.awready_r;
  assign s_axi_wready  = st_r.wready_r;
  assign s_axi_bvalid  = st_r.bvalid_r;
  assign s_axi_bresp   = st_r.bresp_r;
  assign s_axi_arready = st_r.arready_r;
  assign s_axi_rvalid  = st_r.rvalid_r;
  assign s_axi_rdata   = st_r.rdata_r;
  assign s_axi_rresp   = st_r.rresp_r;
  assign peer_fail     = st_r.peer_fail_r;
  assign error_irq     = st_r.irq_r;
endmodule
`default_nettype wire

// ==== testbench/aes_error_summary_checker.sv ====
/* port-level assertions for the adapter error summary block.
   assumes it is bound to aes_error_summary. */
`timescale 1ns/1ps
`default_nettype none
module aes_error_summary_checker
  import aes_pkg::*;
(
  input wire logic        clock,
  input wire logic        reset_n,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire aes_fetch_s  fetch,
  input wire aes_event_s  evt,
  input wire logic [15:0] pending_levels,
  input wire logic        peer_fail,
  input wire logic        error_irq
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  logic ack_bad;
  assign ack_bad = evt.ack_txn & ~evt.passive_release & ~pending_levels[evt.interrupt_priority_level];
  property p_ack_fail; ack_bad |-> ##[1:2] peer_fail; endproperty
  a_ack_fail: assert property (p_ack_fail) else $error("failed acknowledge not reported");
  property p_ill_fail; evt.illegal_cmd |-> ##[1:2] peer_fail; endproperty
  a_ill_fail: assert property (p_ill_fail) else $error("illegal command not reported");
  property p_fail_cause;
    peer_fail |-> $past(ack_bad | evt.illegal_cmd) || $past(ack_bad | evt.illegal_cmd, 2);
  endproperty
  a_fail_cause: assert property (p_fail_cause) else $error("peer failure without cause");
  // irq may only rise on a flagged error or a register write
  property p_irq_rise;
    $rose(error_irq) |-> s_axi_bvalid || $past(fetch.valid & fetch.parity_err) || $past(evt.illegal_confirm_slave_data);
  endproperty
  a_irq_rise: assert property (p_irq_rise) else $error("irq rose without cause");
  property p_irq_fall; $fell(error_irq) |-> s_axi_bvalid; endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("irq fell without write");
  property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");
  property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped");
  property p_aw_block; s_axi_bvalid |-> !s_axi_awready; endproperty
  a_aw_block: assert property (p_aw_block) else $error("address taken during response");
  c_ack: cover property (ack_bad);
  c_irq: cover property ($rose(error_irq));
  c_par: cover property (fetch.valid && fetch.parity_err);
endmodule
bind aes_error_summary aes_error_summary_checker u_chk (.*);
`default_nettype wire

// ==== testbench/aes_peer_model.sv ====
/* peer adapter model: drives link events, fetches and pending levels.
   assumes the bench calls its tasks. */
`timescale 1ns/1ps
`default_nettype none
module aes_peer_model
  import aes_pkg::*;
(
  input  wire logic   clock,
  input  wire logic   peer_fail,
  output aes_fetch_s  fetch,
  output aes_event_s  evt,
  output logic [15:0] pending_levels
);
  int         fails;
  logic [3:0] last_ack;
  initial begin
    fetch = '0;
    evt = '0;
    pending_levels = 16'h0;
    last_ack = 4'hf;
  end
  always @(posedge clock) if (peer_fail) fails++;
  // idle qualifiers flip, so a stale copy is never mistaken for data; strobes drop
  task automatic ev(input aes_event_s e);
    if (e.ack_txn && e.interrupt_priority_level == last_ack) return;
    @(posedge clock);
    evt <= e;
    @(posedge clock);
    evt <= {6'h00, ~e[36:33], 1'b0, ~e[31:0]};
    if (e.ack_txn) last_ack = e.interrupt_priority_level;
  endtask
  task automatic fe(input aes_fetch_s f);
    @(posedge clock);
    fetch <= f;
    @(posedge clock);
    fetch <= {1'h0, ~f[3:0]};
  endtask
  task automatic pend(input logic [15:0] p);
    @(posedge clock);
    pending_levels <= p;
  endtask
endmodule
`default_nettype wire

// ==== testbench/aes_error_summary_tb.sv ====
/* self-checking bench for the adapter error summary block.
   assumes the peer model and the bound checker. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin num_errors++; $display("[ERR] %s exp %h got %h", n, e, s); end end
module aes_error_summary_tb
  import aes_pkg::*;
;
  logic        clock, reset_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, peer_fail, error_irq;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic [15:0] pending_levels, pend;
  aes_fetch_s  fetch;
  aes_event_s  evt;
  int          num_errors, comparisons, cyc, s_m, c_m, a_m, f_m, seed, lk;
  aes_error_summary dut (.*);
  aes_peer_model peer (.*);
  initial begin
    clock = 1'h0;
    forever #2 clock = ~clock;
  end
  task automatic stop_test;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      stop_test;
    end
  end
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    repeat (50) begin
      @(posedge clock);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 1'h0;
    `CHK("bresp", (a > 12'h008) ? 2'h2 : 2'h0, s_axi_bresp)
    if (a == 12'h000) s_m &= ~(v & 32'h8f);
    if (a == 12'h000 && v[0]) lk = 0;
    if (a == 12'h004) c_m = v & 3;
  endtask
  task automatic rd(input logic [11:0] a);
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    repeat (50) begin
      @(posedge clock);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
      if (s_axi_rvalid) break;
    end
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask
  task automatic chk_all;
    rd(12'h000);
    `CHK("summary", s_m, d)
    rd(12'h004);
    `CHK("control", c_m, d)
    rd(12'h008);
    `CHK("fail_addr", a_m, d)
    `CHK("irq", (s_m[0] & c_m[0]) | (s_m[2] & c_m[1]), error_irq)
  endtask
  task automatic go_ev(input aes_event_s e);
    peer.ev(e);
    if (e.io_txn && !s_m[0]) s_m[4] = 1'b1;
    if (e.illegal_cmd) s_m[3] = 1'b1;
    if (e.intlk_read && e.illegal_confirm_slave_data) s_m[2] = 1'b1;
    if (e.ack_txn && !e.passive_release && !pend[e.interrupt_priority_level]) s_m[1] = 1'b1;
    if (e.illegal_cmd || (e.ack_txn && !e.passive_release && !pend[e.interrupt_priority_level])) f_m++;
    if (e.dma_ca && !lk && !s_m[2]) a_m = e.dma_address;
  endtask
  task automatic go_fe(input logic sl);
    peer.fe({2'h3, sl, !sl, sl});
    if (sl) lk = 1;
    if (!s_m[0]) s_m[6:4] = {!sl, sl, !sl};
    s_m[0] = 1'b1;
  endtask
  initial begin
    seed = 32'hcb31;
    reset_n = 1'h0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 56'h0;
    s_axi_wstrb = 4'hf;
    s_m = 32'h10;
    pend = 16'h0;
    repeat (5) @(posedge clock);
    reset_n <= 1'h1;
    chk_all;
    rd(12'h00c);
    `CHK("unmapped", 2'h2, r)
    wr(12'h010, 32'h0);
    wr(12'h000, 32'h70);
    wr(12'h000, 32'h0);
    $display("test reset done");
    repeat (3) go_ev({6'h00, 4'h0, 1'h1, 32'($random(seed))});
    go_ev({6'h20, 37'h0});
    chk_all;
    go_ev({6'h10, 37'h0});
    chk_all;
    wr(12'h000, 32'h8);
    $display("test capture and illegal done");
    pend = (16'($random(seed)) | 16'h0008) & ~16'h0220;
    peer.pend(pend);
    go_ev({6'h02, 4'h3, 33'h0});
    go_ev({6'h03, 4'h5, 33'h0});
    go_ev({6'h02, 4'h9, 33'h0});
    chk_all;
    wr(12'h000, 32'h2);
    $display("test acknowledge done");
    wr(12'h004, 32'h2);
    go_ev({6'h0c, 37'h0});
    go_ev({6'h00, 4'h0, 1'h1, 32'($random(seed))});
    chk_all;
    wr(12'h000, 32'h4);
    go_ev({6'h00, 4'h0, 1'h1, 32'($random(seed))});
    chk_all;
    $display("test interlock done");
    wr(12'h004, 32'h3);
    for (int i = 0; i < 2; i++) begin
      go_fe(i[0] == 1'b0);
      go_ev({6'h20, 37'h0});
      go_ev({6'h00, 4'h0, 1'h1, 32'($random(seed))});
      chk_all;
      wr(12'h000, 32'h1);
      go_ev({6'h20, 37'h0});
      chk_all;
    end
    $display("test parity done");
    `CHK("peer_fail", f_m, peer.fails)
    stop_test;
  end
endmodule
`default_nettype wire
